// >>> hdl/fsc_fifo.sv
// Purpose: word FIFO between the register bus and the serial engine
// Assumes: single clock, synchronous active-low reset
// Notes:   flip-flop storage; full and empty follow the occupancy count
`timescale 1ns/1ns
module fsc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("fsc_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      if (push && !pop) begin
        count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
        count <= count - (AW+1)'(1);
      end
    end
  end
endmodule

// >>> hdl/fsc_pkg.sv
// Purpose: shared constants of the serial flash master ports and control block
// Assumes: 32-bit register bus, byte addressed, one word per register
// Notes:   field positions of the global transfer control word
package fsc_pkg;

  // register byte offsets
  localparam logic [7:0] FSC_OFS_CTRL    = 8'h00;
  localparam logic [7:0] FSC_OFS_TX_DATA = 8'h04;
  localparam logic [7:0] FSC_OFS_RX_DATA = 8'h08;

  // global transfer control fields
  localparam int FSC_BIT_SOFT_RESET = 31;
  localparam int FSC_BIT_INT_EN     = 20;
  localparam int FSC_DIV_MSB        = 19;
  localparam int FSC_DIV_LSB        = 12;
  localparam int FSC_BIT_LOW_FIRST  = 10;
  localparam int FSC_BIT_PROTECT    = 9;
  localparam int FSC_BIT_USE_DMA    = 8;
  localparam int FSC_PH_MSB         = 6;
  localparam int FSC_PH_LSB         = 4;
  localparam int FSC_BIT_ERROR      = 2;
  localparam int FSC_BIT_DONE       = 1;
  localparam int FSC_BIT_START      = 0;

  // reset values
  localparam logic [7:0] FSC_DIV_RST        = 8'h08;
  localparam logic       FSC_PROTECT_RST    = 1'h1;
  localparam logic [8:0] FSC_DIV_ZERO_HALF  = 9'h080;

  // bus answers
  localparam logic [1:0] FSC_RESP_OKAY  = 2'h0;
  localparam logic [1:0] FSC_RESP_ERROR = 2'h1;

  // serial word
  localparam int FSC_WORD_BITS = 32;
  localparam int FSC_FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    FSC_IDLE   = 3'b000,
    FSC_LOAD   = 3'b001,
    FSC_SHIFT  = 3'b010,
    FSC_NEXT   = 3'b011,
    FSC_FINISH = 3'b100
  } fsc_state_t;

endpackage

// >>> hdl/fsc_top.sv
// Purpose: serial flash master, bus slave, control register and pad drive
// Assumes: one clock sys_clk at 10 MHz; pad inputs are asynchronous
// Notes:   each phase moves one word from the transmit FIFO on line 0
//          and captures one word from line 1 into the receive register
// Functional notes
// - The global transfer control register sits at offset zero with all its fields.
// - Writing one to bit 31 holds every register and circuit but that bit in reset; the code keeps the bus slave and the pad synchronizers on the pin reset.
// - The completion interrupt is high while the enable bit and the done flag are both one.
// - A transmit DMA request is driven and withdrawn by the controller's clear pulse.
// - A receive DMA request is driven and withdrawn by the controller's clear pulse; the code lets a fresh receive word in the same cycle win over the clear.
// - The registers are reached as a bus slave with the documented address and data signals.
// - Line 0 has its own output data and output enable toward the pad.
// - Line 1 has its own output data and output enable toward the pad.
// - Line 2 serves as the active-low write-protect line with its own data and enable.
// - Line 3 serves as the active-low hold line with its own data and enable.
// - Each data line is sampled through its own pad input, apart from its output path.
// - Serial clock and chip select are pad outputs; a communication spans select low.
// - The serial clock is the system clock divided by the divider field, zero meaning 256; the code rounds odd values down to even, one giving 512.
// - With the byte order bit set, byte 7:0 goes first up to 31:24, else the reverse.
// - A start runs phases zero upward to the configured count, then ends the communication.
`timescale 1ns/1ns
module fsc_top
  import fsc_pkg::*;
#(
  parameter int FIFO_DEPTH = FSC_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // register bus slave
  input  wire logic        hsel,
  input  wire logic        hwrite,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hreadyin,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic [1:0]       hresp,
  // dma single requests
  input  wire logic        tx_dma_request_clear,
  input  wire logic        rx_dma_request_clear,
  output logic             tx_dma_request,
  output logic             rx_dma_request,
  // completion interrupt
  output logic             done_irq,
  // serial pads
  output logic             sck,
  output logic             chip_select_low,
  input  wire logic        line0_in,
  output logic             line0_out,
  output logic             line0_drive_en,
  input  wire logic        line1_in,
  output logic             line1_out,
  output logic             line1_drive_en,
  input  wire logic        line2_in,
  output logic             line2_protect_out,
  output logic             line2_protect_drive_en,
  input  wire logic        line3_in,
  output logic             line3_pause_out,
  output logic             line3_pause_drive_en
);
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("fsc_top: FIFO_DEPTH must be at least 2");
    end
  end

  // control fields
  logic             soft_reset;
  logic             int_en;
  logic [7:0]       clock_divider_value;
  logic             byte_order_low_first;
  logic             protect;
  logic             use_dma;
  logic [2:0]       phase_total;
  logic             xfer_error;
  logic             xfer_done;
  logic             xfer_start;
  logic             blk_rst_n;

  // bus slave state
  logic             ap_ctrl_wr;
  logic             tx_pend;
  logic             err_stage;
  logic             ap_take;

  // engine state
  fsc_state_t       state;
  logic [2:0]       phase;
  logic [5:0]       bit_idx;
  logic [7:0]       half_cnt;
  logic [31:0]      tx_word;
  logic [31:0]      rx_shift;
  logic [31:0]      rx_data;
  logic [3:0]       line_meta;
  logic [3:0]       line_sync;
  logic             edge_now;

  // fifo
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic             fifo_pop;
  logic [31:0]      fifo_out_data;

  logic [31:0]      ctrl_word;
  logic [7:0]       half_div;
  logic [4:0]       bit_pos;
  logic             done_set;

  // software reset holds everything but its own bit, the bus slave and the pad synchronizers
  assign blk_rst_n = rst_n && !soft_reset;

  assign ctrl_word = {soft_reset, 10'h000, int_en, clock_divider_value, 1'b0,
                      byte_order_low_first, protect, use_dma, 1'b0, phase_total,
                      1'b0, xfer_error, xfer_done, xfer_start};

  // zero selects divide by 256; odd values are rounded down to even
  assign half_div = (clock_divider_value == 8'h00) ? FSC_DIV_ZERO_HALF[7:0]
                                                   : {1'b0, clock_divider_value[7:1]};

  // byte k of the word is chosen by the order bit, bits go msb first
  always_comb begin
    bit_pos = 5'h00;
    if (byte_order_low_first) begin
      bit_pos = {bit_idx[4:3], ~bit_idx[2:0]};
    end else begin
      bit_pos = {~bit_idx[4:3], ~bit_idx[2:0]};
    end
  end

  assign ap_take  = hsel && htrans[1] && hreadyin;
  assign edge_now = (state == FSC_SHIFT) && (half_cnt == half_div - 8'h01);
  assign fifo_pop = (state == FSC_LOAD) && fifo_out_valid;
  assign done_set = (state == FSC_FINISH);

  fsc_fifo #(
    .WIDTH (FSC_WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (blk_rst_n),
    .in_valid  (tx_pend),
    .in_ready  (fifo_in_ready),
    .in_data   (hwdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // bus address phase and answers; kept on the pin reset so a bus cycle
  // in flight survives a software reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ap_ctrl_wr <= 1'b0;
      tx_pend    <= 1'b0;
      err_stage  <= 1'b0;
      hreadyout  <= 1'b1;
      hresp      <= FSC_RESP_OKAY;
      hrdata     <= 32'h0000_0000;
    end else begin
      ap_ctrl_wr <= 1'b0;
      if (err_stage) begin
        err_stage <= 1'b0;
        hreadyout <= 1'b1;
      end else if (tx_pend) begin
        // wait states until the FIFO takes the word
        if (fifo_in_ready) begin
          tx_pend   <= 1'b0;
          hreadyout <= 1'b1;
        end
      end else if (ap_take) begin
        hresp    <= FSC_RESP_OKAY;
        hrdata   <= 32'h0000_0000;
        case (haddr[7:0])
          FSC_OFS_CTRL: begin
            ap_ctrl_wr <= hwrite;
            hrdata     <= ctrl_word;
          end
          FSC_OFS_TX_DATA: begin
            tx_pend   <= hwrite;
            hreadyout <= !hwrite;
          end
          FSC_OFS_RX_DATA: begin
            hrdata <= rx_data;
          end
          default: begin
            err_stage <= 1'b1;
            hreadyout <= 1'b0;
            hresp     <= FSC_RESP_ERROR;
          end
        endcase
      end else if (hreadyout) begin
        hresp <= FSC_RESP_OKAY;
      end
    end
  end

  // the reset bit, like the bus slave and the pad synchronizers, ignores the software reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      soft_reset <= 1'b0;
    end else if (ap_ctrl_wr) begin
      soft_reset <= hwdata[FSC_BIT_SOFT_RESET];
    end
  end

  // writable control fields
  always_ff @(posedge sys_clk) begin
    if (!blk_rst_n) begin
      int_en               <= 1'b0;
      clock_divider_value  <= FSC_DIV_RST;
      byte_order_low_first <= 1'b0;
      protect              <= FSC_PROTECT_RST;
      use_dma              <= 1'b0;
      phase_total          <= 3'h0;
    end else if (ap_ctrl_wr) begin
      int_en               <= hwdata[FSC_BIT_INT_EN];
      clock_divider_value  <= hwdata[FSC_DIV_MSB:FSC_DIV_LSB];
      byte_order_low_first <= hwdata[FSC_BIT_LOW_FIRST];
      protect              <= hwdata[FSC_BIT_PROTECT];
      use_dma              <= hwdata[FSC_BIT_USE_DMA];
      phase_total          <= hwdata[FSC_PH_MSB:FSC_PH_LSB];
    end
  end

  // start clears itself when taken; done and error clear on a written one,
  // and a setting event in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (!blk_rst_n) begin
      xfer_start <= 1'b0;
      xfer_done  <= 1'b0;
      xfer_error <= 1'b0;
    end else begin
      if (state == FSC_IDLE && xfer_start) begin
        xfer_start <= 1'b0;
      end else if (ap_ctrl_wr && hwdata[FSC_BIT_START]) begin
        xfer_start <= 1'b1;
      end
      if (done_set) begin
        xfer_done <= 1'b1;
      end else if (ap_ctrl_wr && hwdata[FSC_BIT_DONE]) begin
        xfer_done <= 1'b0;
      end
      if (state == FSC_LOAD && !fifo_out_valid) begin
        xfer_error <= 1'b1;
      end else if (ap_ctrl_wr && hwdata[FSC_BIT_ERROR]) begin
        xfer_error <= 1'b0;
      end
    end
  end

  // pad inputs pass two flip-flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      line_meta <= 4'h0;
      line_sync <= 4'h0;
    end else begin
      line_meta <= {line3_in, line2_in, line1_in, line0_in};
      line_sync <= line_meta;
    end
  end

  // phase engine: mode 0, data changes on the falling edge, sampled rising
  always_ff @(posedge sys_clk) begin
    if (!blk_rst_n) begin
      state           <= FSC_IDLE;
      phase           <= 3'h0;
      bit_idx         <= 6'h00;
      half_cnt        <= 8'h00;
      tx_word         <= 32'h0000_0000;
      rx_shift        <= 32'h0000_0000;
      rx_data         <= 32'h0000_0000;
      sck             <= 1'b0;
      chip_select_low <= 1'b1;
      line0_out       <= 1'b0;
      line0_drive_en  <= 1'b0;
    end else begin
      case (state)
        FSC_IDLE: begin
          if (xfer_start) begin
            phase <= 3'h0;
            state <= FSC_LOAD;
          end
        end
        FSC_LOAD: begin
          if (fifo_out_valid) begin
            tx_word         <= fifo_out_data;
            bit_idx         <= 6'h00;
            half_cnt        <= 8'h00;
            chip_select_low <= 1'b0;
            line0_drive_en  <= 1'b1;
            state           <= FSC_SHIFT;
          end else begin
            state <= FSC_FINISH;
          end
        end
        FSC_SHIFT: begin
          line0_out <= tx_word[bit_pos];
          if (edge_now) begin
            half_cnt <= 8'h00;
            sck      <= !sck;
            if (!sck) begin
              rx_shift[bit_pos] <= line_sync[1];
            end else if (bit_idx == 6'(FSC_WORD_BITS - 1)) begin
              state <= FSC_NEXT;
            end else begin
              bit_idx <= bit_idx + 6'h01;
            end
          end else begin
            half_cnt <= half_cnt + 8'h01;
          end
        end
        FSC_NEXT: begin
          rx_data <= rx_shift;
          if (phase == phase_total) begin
            state <= FSC_FINISH;
          end else begin
            phase <= phase + 3'h1;
            state <= FSC_LOAD;
          end
        end
        FSC_FINISH: begin
          chip_select_low <= 1'b1;
          line0_drive_en  <= 1'b0;
          state           <= FSC_IDLE;
        end
        default: begin
          state <= FSC_IDLE;
        end
      endcase
    end
  end

  // line 1 is the flash output in single line mode, never driven here
  always_ff @(posedge sys_clk) begin
    if (!blk_rst_n) begin
      line1_out      <= 1'b0;
      line1_drive_en <= 1'b0;
    end else begin
      line1_out      <= 1'b0;
      line1_drive_en <= 1'b0;
    end
  end

  // write-protect and hold are driven whenever not in reset
  always_ff @(posedge sys_clk) begin
    if (!blk_rst_n) begin
      line2_protect_out      <= 1'b1;
      line2_protect_drive_en <= 1'b0;
      line3_pause_out        <= 1'b1;
      line3_pause_drive_en   <= 1'b0;
    end else begin
      line2_protect_out      <= !protect;
      line2_protect_drive_en <= 1'b1;
      line3_pause_out        <= 1'b1;
      line3_pause_drive_en   <= 1'b1;
    end
  end

  // dma requests: a clear withdraws the request; a fresh rx word wins over it
  always_ff @(posedge sys_clk) begin
    if (!blk_rst_n) begin
      tx_dma_request <= 1'b0;
      rx_dma_request <= 1'b0;
    end else begin
      if (tx_dma_request_clear) begin
        tx_dma_request <= 1'b0;
      end else if (use_dma && fifo_in_ready && !tx_pend) begin
        tx_dma_request <= 1'b1;
      end
      if (use_dma && state == FSC_NEXT) begin
        rx_dma_request <= 1'b1;
      end else if (rx_dma_request_clear) begin
        rx_dma_request <= 1'b0;
      end
    end
  end

  // completion interrupt follows the done flag
  always_ff @(posedge sys_clk) begin
    if (!blk_rst_n) begin
      done_irq <= 1'b0;
    end else begin
      // one edge behind the flag, so the line rises only once select is high
      done_irq <= int_en && xfer_done;
    end
  end
endmodule

// >>> tb/fsc_flash_model.sv
// Purpose: behavioural serial flash on the far side of the pads
// Assumes: single-line traffic, line 0 into the flash, line 1 out of it
// Notes:   keeps the last eight words received; line 1 idles at pull-up
`timescale 1ns/1ns
module fsc_flash_model #(
  parameter logic [31:0] REPLY = 32'hC3A5_5A3C
) (
  input  wire logic sck,
  input  wire logic chip_select_low,
  input  wire logic data_in,
  output logic      data_out
);
  logic [31:0] shreg;
  logic [31:0] words [0:7];
  int          n_words;
  int          bit_cnt;

  initial begin
    data_out = 1'b1;
    n_words  = 0;
    bit_cnt  = 0;
    shreg    = 32'h0;
  end

  always @(negedge chip_select_low) begin
    bit_cnt  = 0;
    data_out = REPLY[31];
  end

  // released line returns to the pull-up, never the last bit
  always @(posedge chip_select_low) data_out = 1'b1;

  always @(posedge sck) begin
    if (!chip_select_low) begin
      shreg = {shreg[30:0], data_in};
      bit_cnt++;
      if (bit_cnt % 32 == 0) begin
        words[n_words % 8] = shreg;
        n_words++;
      end
    end
  end

  always @(negedge sck) begin
    if (!chip_select_low) data_out = REPLY[31 - (bit_cnt % 32)];
  end
endmodule

// >>> tb/fsc_top_monitor.sv
// Purpose: port-level checker of the serial flash master
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every instance of the top module
`timescale 1ns/1ns
module fsc_top_monitor
  import fsc_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // register bus
  input wire logic        hsel,
  input wire logic        hwrite,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hreadyin,
  input wire logic        hreadyout,
  input wire logic [1:0]  hresp,
  // dma and interrupt
  input wire logic        tx_dma_request_clear,
  input wire logic        rx_dma_request_clear,
  input wire logic        tx_dma_request,
  input wire logic        rx_dma_request,
  input wire logic        done_irq,
  // pads
  input wire logic        sck,
  input wire logic        chip_select_low,
  input wire logic        line0_drive_en,
  input wire logic        line1_out,
  input wire logic        line1_drive_en,
  input wire logic        line3_pause_out,
  input wire logic        line3_pause_drive_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_taken;
    hsel && htrans[1] && hreadyin && hreadyout;
  endsequence
  sequence s_err_tail;
    !hreadyout ##1 (hresp == FSC_RESP_ERROR && hreadyout) ##1 (hresp == FSC_RESP_OKAY);
  endsequence

  a_ctrl_zero_wait: assert property (s_taken ##0 (haddr == 32'h0) |=> hreadyout)
    else $error("control access stalled");
  a_tx_push_wait: assert property (s_taken ##0 (hwrite && haddr == 32'h4)
    |=> !hreadyout ##[1:20] hreadyout) else $error("data push wait wrong");
  a_error_two_cycle: assert property ($rose(hresp == FSC_RESP_ERROR) |-> s_err_tail)
    else $error("error answer shape wrong");
  a_reset_pads_idle: assert property (!$past(rst_n)
    |-> chip_select_low && !line0_drive_en && !line3_pause_drive_en)
    else $error("pads active after reset");
  a_sck_in_frame: assert property ($rose(sck) |-> !chip_select_low)
    else $error("clock edge outside frame");
  a_sck_idle_low: assert property (chip_select_low |-> !sck)
    else $error("clock not idle low");
  a_line0_in_frame: assert property (line0_drive_en |-> !chip_select_low)
    else $error("line 0 driven outside frame");
  a_line1_input: assert property (!line1_drive_en && !line1_out)
    else $error("line 1 driven");
  a_hold_high: assert property (line3_pause_out)
    else $error("hold line asserted");
  a_tx_clear_drop: assert property (tx_dma_request && tx_dma_request_clear
    |=> !tx_dma_request) else $error("tx request not withdrawn");
  a_rx_clear_drop: assert property (rx_dma_request && rx_dma_request_clear
    && chip_select_low |=> !rx_dma_request) else $error("rx request not withdrawn");
  a_irq_after_end: assert property ($rose(done_irq) |-> chip_select_low
    && $past(chip_select_low)) else $error("interrupt inside frame");
endmodule

bind fsc_top fsc_top_monitor u_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .hwrite(hwrite), .haddr(haddr),
  .htrans(htrans), .hreadyin(hreadyin), .hreadyout(hreadyout), .hresp(hresp),
  .tx_dma_request_clear(tx_dma_request_clear), .rx_dma_request_clear(rx_dma_request_clear),
  .tx_dma_request(tx_dma_request), .rx_dma_request(rx_dma_request), .done_irq(done_irq),
  .sck(sck), .chip_select_low(chip_select_low), .line0_drive_en(line0_drive_en),
  .line1_out(line1_out), .line1_drive_en(line1_drive_en), .line3_pause_out(line3_pause_out),
  .line3_pause_drive_en(line3_pause_drive_en));

// >>> tb/tb.sv
// Purpose: register-level test of the serial flash master
// Assumes: pads pulled up when nobody drives them
// Notes:   inputs change on the falling clock edge only
`timescale 1ns/1ns
module tb;
  import fsc_pkg::*;
  localparam logic [31:0] REPLY = 32'hC3A5_5A3C;
  logic        sys_clk, rst_n, hsel, hwrite, hreadyin;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans, hresp, rs;
  logic [2:0]  hsize;
  logic        hreadyout, tx_dma_request_clear, rx_dma_request_clear;
  logic        tx_dma_request, rx_dma_request, done_irq, sck, chip_select_low;
  logic        line0_out, line0_drive_en, line1_out, line1_drive_en, flash_out;
  logic        line2_protect_out, line2_protect_drive_en, line3_pause_out, line3_pause_drive_en;
  wire logic   line0_in = line0_drive_en ? line0_out : 1'b1;
  wire logic   line1_in = line1_drive_en ? line1_out : flash_out;
  wire logic   line2_in = line2_protect_drive_en ? line2_protect_out : 1'b1;
  wire logic   line3_in = line3_pause_drive_en ? line3_pause_out : 1'b1;
  int          n_fail, check_count;
  time         t_last, t_prev;

  fsc_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .hwrite(hwrite),
    .haddr(haddr), .htrans(htrans), .hsize(hsize), .hwdata(hwdata), .hreadyin(hreadyin),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .tx_dma_request_clear(tx_dma_request_clear), .rx_dma_request_clear(rx_dma_request_clear),
    .tx_dma_request(tx_dma_request), .rx_dma_request(rx_dma_request), .done_irq(done_irq),
    .sck(sck), .chip_select_low(chip_select_low), .line0_in(line0_in), .line0_out(line0_out),
    .line0_drive_en(line0_drive_en), .line1_in(line1_in), .line1_out(line1_out),
    .line1_drive_en(line1_drive_en), .line2_in(line2_in), .line2_protect_out(line2_protect_out),
    .line2_protect_drive_en(line2_protect_drive_en), .line3_in(line3_in),
    .line3_pause_out(line3_pause_out), .line3_pause_drive_en(line3_pause_drive_en));
  fsc_flash_model #(.REPLY(REPLY)) u_flash (.sck(sck), .chip_select_low(chip_select_low),
    .data_in(line0_in), .data_out(flash_out));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sck) begin
    t_prev = t_last;
    t_last = $time;
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, want);
    end
  endtask
  // data stays on hwdata through every wait state
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd_v, output logic [1:0] rs_v);
    int n;
    @(negedge sys_clk);
    hsel = 1'b1; htrans = 2'h2; hwrite = wr; haddr = {24'h0, a};
    @(negedge sys_clk);
    hsel = 1'b0; htrans = 2'h0; hwdata = d; n = 0;
    while (hreadyout !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 100) begin
      n_fail++;
      stop_test();
    end
    rd_v = hrdata;
    rs_v = hresp;
    // the data phase completes at the next rising edge, hwdata still held
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic [1:0]  s;
    bus(1'b1, a, d, x, s);
    // outputs derived from the new fields follow one edge later
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    logic [1:0] s;
    bus(1'b0, a, 32'h0, x, s);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    rd(FSC_OFS_CTRL, r);
    while (r[FSC_BIT_DONE] !== 1'b1 && n < 6000) begin
      rd(FSC_OFS_CTRL, r);
      n++;
    end
    if (n >= 6000) begin
      n_fail++;
      stop_test();
    end
  endtask
  task automatic pulse_clear(input logic tx);
    @(negedge sys_clk);
    if (tx) tx_dma_request_clear = 1'b1;
    else rx_dma_request_clear = 1'b1;
    @(negedge sys_clk);
    tx_dma_request_clear = 1'b0;
    rx_dma_request_clear = 1'b0;
  endtask
  function automatic logic [31:0] cfg(input logic [7:0] div, input logic [2:0] ph,
                                      input logic lf, pr, dma, ie, st);
    return {11'h000, ie, div, 1'b0, lf, pr, dma, 1'b0, ph, 3'h0, st};
  endfunction

  initial begin
    rst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0; hreadyin = 1'b1; haddr = 32'h0;
    hwdata = 32'h0; htrans = 2'h0; hsize = 3'h2; n_fail = 0; check_count = 0;
    tx_dma_request_clear = 1'b0; rx_dma_request_clear = 1'b0; t_last = 0; t_prev = 0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(FSC_OFS_CTRL, r);
    check(r, 32'h0000_8200);
    check(line2_protect_out, 1'b0);
    check(line3_pause_drive_en, 1'b1);
    bus(1'b0, 8'h10, 32'h0, r, rs);
    check(rs, FSC_RESP_ERROR);
    // eight words fill the buffer, then eight phases drain it in order
    wr(FSC_OFS_CTRL, cfg(8'h08, 3'h7, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0));
    check(tx_dma_request, 1'b1);
    pulse_clear(1'b1);
    check(tx_dma_request, 1'b0);
    for (int i = 0; i < 8; i++) wr(FSC_OFS_TX_DATA, 32'h0102_0304 + 32'h1010_1010 * 32'(i));
    pulse_clear(1'b1);
    @(negedge sys_clk);
    check(tx_dma_request, 1'b0);
    wr(FSC_OFS_CTRL, cfg(8'h08, 3'h7, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1));
    wait_done();
    check(u_flash.n_words, 8);
    for (int i = 0; i < 8; i++) check(u_flash.words[i], 32'h0102_0304 + 32'h1010_1010 * 32'(i));
    check(32'(t_last - t_prev), 32'h320);
    rd(FSC_OFS_RX_DATA, r);
    check(r, REPLY);
    check(rx_dma_request, 1'b1);
    pulse_clear(1'b0);
    check(rx_dma_request, 1'b0);
    check(done_irq, 1'b1);
    check({chip_select_low, line0_drive_en}, 2'h2);
    wr(FSC_OFS_CTRL, cfg(8'h08, 3'h0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0) | 32'h6);
    check(done_irq, 1'b0);
    check(line2_protect_out, 1'b1);
    // low byte first with divider zero, a 256-clock period
    wr(FSC_OFS_TX_DATA, 32'h1234_5678);
    wr(FSC_OFS_CTRL, cfg(8'h00, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
    wait_done();
    check(u_flash.words[0], 32'h7856_3412);
    rd(FSC_OFS_RX_DATA, r);
    check(r, 32'h3C5A_A5C3);
    check(32'(t_last - t_prev), 32'h6400);
    // start with nothing queued must end in error, not hang
    wr(FSC_OFS_CTRL, cfg(8'h08, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0) | 32'h6);
    wr(FSC_OFS_CTRL, cfg(8'h08, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1));
    wait_done();
    check(r[FSC_BIT_ERROR], 1'b1);
    wr(FSC_OFS_CTRL, 32'h8000_0170);
    rd(FSC_OFS_CTRL, r);
    check(r, 32'h8000_8200);
    check({chip_select_low, line2_protect_drive_en, line0_drive_en}, 3'h4);
    wr(FSC_OFS_CTRL, 32'h0000_8200);
    stop_test();
  end
endmodule
